// >>> pd_link_assertions.sv
// Concurrent checks on the manager to controller link
`timescale 1ns/1ns
module pd_link_assertions
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Link signals
   input wire logic frame,
   input wire logic ptr_ld,
   input wire logic [7:0] ptr_val,
   input wire logic wr_stb,
   input wire logic [7:0] wr_byte,
   input wire logic rd_stb,
   input wire logic [7:0] rd_byte,
   input wire logic alert_n
);
   logic [7:0] ptr_q;
   logic [7:0] ptr_d;
   logic mapped;

   // ****************************************
   // Pointer shadow
   // ****************************************
   // Mirrors the device pointer, both cleared by reset
   always_comb
   begin
      ptr_d = ptr_q;
      if (ptr_ld)
         ptr_d = ptr_val;
      else if (wr_stb || rd_stb)
         ptr_d = 8'(ptr_q + 8'h01);
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
         ptr_q <= 8'h00;
      else
         ptr_q <= ptr_d;
   end

   // Places that may read back non-zero
   assign mapped = (ptr_q == 8'h10) || (ptr_q == 8'h11) || (ptr_q >= 8'h30 && ptr_q <= 8'h4F);

   // ****************************************
   // Properties
   // ****************************************
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   // Read of the low flags, then its answer
   sequence low_read;
      rd_stb && ptr_q == 8'h10;
   endsequence
   sequence low_read_set;
      low_read ##1 rd_byte != 8'h00;
   endsequence

   rd_data_hold_a: assert property (!$past(rd_stb) |-> $stable(rd_byte))
      else $error("read byte moved without a read strobe");
   strobe_onehot_a: assert property ($onehot0({ptr_ld, wr_stb, rd_stb}))
      else $error("two link strobes in one cycle");
   unmapped_zero_a: assert property (rd_stb && !mapped |=> rd_byte == 8'h00)
      else $error("write-only or unmapped place read non-zero");
   low_bits_a: assert property (low_read |=> (rd_byte & 8'hBB) == 8'h00)
      else $error("unused low flag bit set");
   high_bits_a: assert property (rd_stb && ptr_q == 8'h11 |=> (rd_byte & 8'hFD) == 8'h00)
      else $error("unused high flag bit set");
   alert_tie_a: assert property (low_read_set |-> !alert_n)
      else $error("flag set while alert line high");
   alert_release_a: assert property ($rose(alert_n) |-> $past(wr_stb))
      else $error("alert released without a clearing write");
   frame_first_a: assert property ($rose(frame) |-> !wr_stb)
      else $error("write strobe in first frame cycle");
   sop_type_a: assert property (rd_stb && ptr_q == 8'h31 |=> rd_byte == 8'h00)
      else $error("packet type byte not zero");
endmodule

// >>> pd_link_if.sv
// Register link between port manager and port controller
`timescale 1ns/1ns
interface pd_link_if;
   logic frame;
   logic ptr_ld;
   logic [7:0] ptr_val;
   logic wr_stb;
   logic [7:0] wr_byte;
   logic rd_stb;
   logic [7:0] rd_byte;
   logic alert_n;
   modport dev (input frame, ptr_ld, ptr_val, wr_stb, wr_byte, rd_stb, output rd_byte, alert_n);
   modport mgr (output frame, ptr_ld, ptr_val, wr_stb, wr_byte, rd_stb, input rd_byte, alert_n);
endinterface

// >>> pd_msg_params.svh
// Constants for the port controller message path and its manager
// Contract
// - CC line biphase-mark coded both ways
// - Hardware appends and checks message CRC
// - Valid received message pulls alert pin low
// - Status changes latched at 0x10/0x11 until cleared
// - Manager reads both alert registers after alert
// - Received message sets low alert bit D2
// - Receive buffer: 32 bytes from 0x30
// - Pointer advances after every byte moved
// - Byte0 significant count, byte1 start-of-packet type
// - Header in bytes 2 and 3, low first
// - Stale receive bytes kept; manager uses count
// - Writing one to D2 clears, alert releases
// - Transmit buffer of 31 byte registers
// - Transmission starts only on command write 0x50
// - Split buffer load gives link error, no send
// - First transmit byte counts following bytes
// - Two header bytes, four per data object
// - Command 0x30 sends with CRC, coded
// - Sent message sets D6, alert low
`ifndef PD_MSG_PARAMS_SVH
`define PD_MSG_PARAMS_SVH

// ****************************************
// Device register map
// ****************************************
`define ADDR_ALERT_L 8'h10
`define ADDR_ALERT_H 8'h11
`define ADDR_RXBUF 8'h30
`define RXBUF_LEN 8'h20
`define ADDR_CMD 8'h50
`define ADDR_TXBUF 8'h51
`define TXBUF_LEN 8'h1F
`define MAX_PAYLOAD 8'h1E
`define CMD_SEND 8'h30
`define BIT_RX_MSG 2
`define BIT_TX_OK 6
`define BIT_LINK_ERR 1

// ****************************************
// Line coding and timing
// ****************************************
`define CLK_NS 100
`define UI_NS 800
`define UI_CYC (`UI_NS / `CLK_NS)
`define UI_LAST 3'((`UI_CYC) - 1)
`define UI_HALF 3'((`UI_CYC) / 2)
`define SHORT_MAX 4'((3 * (`UI_CYC)) / 4 - 1)
`define IDLE_CYC 4'((3 * (`UI_CYC)) / 2)
`define IDLE_LAST 4'((3 * (`UI_CYC)) / 2 - 1)
`define PRE_LAST 8'h0F
`define SOP_LAST 8'h07
`define CRC_LAST 8'h1F
`define TAIL_LAST 8'h01
`define SOP_CODE 8'hC3
`define SOP_TYPE 8'h00
`define CRC_POLY 32'h04C11DB7
`define CRC_INIT 32'hFFFFFFFF

// ****************************************
// Manager software registers
// ****************************************
`define MGR_CTRL 3'h0
`define MGR_PTR 3'h1
`define MGR_WDATA 3'h2
`define MGR_RDREQ 3'h3
`define MGR_RDATA 3'h4
`define MGR_STATUS 3'h5

`endif

// >>> pd_msg_pkg.sv
// Types shared by the message path ends
package pd_msg_pkg;
   typedef enum logic [2:0] {TX_IDLE = 3'h0, TX_PRE = 3'h1, TX_SOP = 3'h3, TX_BODY = 3'h2,
                             TX_CRC = 3'h6, TX_TAIL = 3'h7} tx_state_t;
   typedef enum logic {RX_HUNT = 1'h0, RX_BODY = 1'h1} rx_state_t;
endpackage

// >>> pd_port_ctrl.sv
// Port controller logic: alert flags, message buffers, CC line coder
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ns
`include "pd_msg_params.svh"
module pd_port_ctrl
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Manager link
   pd_link_if.dev link,
   // CC pin, enable low while driving
   input wire logic cc_i,
   output logic cc_o,
   output logic cc_oe_n_o,
   // Status
   output logic tx_busy_o
);
   localparam logic [7:0] SOP = `SOP_CODE;

   logic [7:0] rx_buf_q [0:`RXBUF_LEN-1];
   logic [7:0] tx_buf_q [0:`TXBUF_LEN-1];
   logic [7:0] ptr_q;
   logic [7:0] rd_byte_q;
   logic [7:0] alert_l_q, alert_l_d, alert_h_q, alert_h_d;
   logic alert_n_q;
   logic frame_q, wr_tx, load_ok_q, tx_valid_q, cmd_wr, launch, link_err;
   logic [4:0] load_cnt_q;
   pd_msg_pkg::tx_state_t tx_st_q, tx_next;
   logic [2:0] ui_q;
   logic [7:0] bitcnt_q, tx_len, phase_last;
   logic [31:0] tx_crc_q;
   logic line_q, tx_bit, tx_done;
   logic cc_s1_q, cc_s2_q, cc_s3_q, half_q, rx_edge, rx_bit, rx_bit_v, rx_end, rx_ok, rx_byte_v;
   logic [3:0] gap_q;
   pd_msg_pkg::rx_state_t rx_st_q;
   logic [7:0] rx_sh_q, rx_len_q, rx_byte;
   logic [8:0] rx_n_q;
   logic [5:0] rx_wr_idx;
   logic [31:0] rx_dl_q, rx_crc_q;

   // ****************************************
   // Address decoding
   // ****************************************
   function automatic logic in_rx(input logic [7:0] a);
      return (a >= `ADDR_RXBUF) && (a < 8'(`ADDR_RXBUF + `RXBUF_LEN));
   endfunction

   function automatic logic in_tx(input logic [7:0] a);
      return (a >= `ADDR_TXBUF) && (a < 8'(`ADDR_TXBUF + `TXBUF_LEN));
   endfunction

   function automatic logic [31:0] crc_step(input logic [31:0] c, input logic b);
      return {c[30:0], 1'b0} ^ ((c[31] ^ b) ? `CRC_POLY : 32'h00000000);
   endfunction

   // ****************************************
   // Register link
   // ****************************************
   // Pointer steps after each byte, so block and single reads walk alike
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
         ptr_q <= 8'h00;
      else if (link.ptr_ld)
         ptr_q <= link.ptr_val;
      else if (link.rd_stb || link.wr_stb)
         ptr_q <= 8'(ptr_q + 8'h01);
   end

   // Read data one cycle after the strobe; write-only space reads zero
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
         rd_byte_q <= 8'h00;
      else if (link.rd_stb)
      begin
         if (ptr_q == `ADDR_ALERT_L)
            rd_byte_q <= alert_l_q;
         else if (ptr_q == `ADDR_ALERT_H)
            rd_byte_q <= alert_h_q;
         else if (in_rx(ptr_q))
            rd_byte_q <= rx_buf_q[5'(ptr_q - `ADDR_RXBUF)];
         else
            rd_byte_q <= 8'h00;
      end
   end

   assign link.rd_byte = rd_byte_q;
   assign link.alert_n = alert_n_q;

   // ****************************************
   // Transmit buffer and load check
   // ****************************************
   assign wr_tx = link.wr_stb && in_tx(ptr_q);
   assign cmd_wr = link.wr_stb && (ptr_q == `ADDR_CMD) && (link.wr_byte == `CMD_SEND);
   assign launch = cmd_wr && tx_valid_q && (tx_st_q == pd_msg_pkg::TX_IDLE);
   assign link_err = cmd_wr && !launch;

   // Staging registers, no reset needed: data only
   always_ff @(posedge ref_clk_i)
   begin
      if (wr_tx)
         tx_buf_q[5'(ptr_q - `ADDR_TXBUF)] <= link.wr_byte;
   end

   // A load counts only if one frame wrote from the base through the count
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         frame_q <= 1'b0;
         load_ok_q <= 1'b0;
         load_cnt_q <= 5'h00;
         tx_valid_q <= 1'b0;
      end
      else
      begin
         frame_q <= link.frame;
         if (link.frame && !frame_q)
         begin
            load_ok_q <= 1'b0;
            load_cnt_q <= 5'h00;
         end
         else if (wr_tx)
         begin
            tx_valid_q <= 1'b0;
            if (ptr_q == `ADDR_TXBUF)
            begin
               load_ok_q <= 1'b1;
               load_cnt_q <= 5'h01;
            end
            else if (load_ok_q)
               load_cnt_q <= 5'(load_cnt_q + 5'h01);
         end
         else if (!link.frame && frame_q && load_ok_q)
         begin
            load_ok_q <= 1'b0;
            tx_valid_q <= ({3'h0, load_cnt_q} > tx_len);
         end
         else if (launch)
            tx_valid_q <= 1'b0;
      end
   end

   // ****************************************
   // Alert flags
   // ****************************************
   // Hardware set wins over a clear in the same cycle
   always_comb
   begin
      alert_l_d = alert_l_q;
      alert_h_d = alert_h_q;
      if (link.wr_stb && (ptr_q == `ADDR_ALERT_L))
         alert_l_d = alert_l_q & ~link.wr_byte;
      if (link.wr_stb && (ptr_q == `ADDR_ALERT_H))
         alert_h_d = alert_h_q & ~link.wr_byte;
      if (rx_ok)
         alert_l_d[`BIT_RX_MSG] = 1'b1;
      if (tx_done)
         alert_l_d[`BIT_TX_OK] = 1'b1;
      if (link_err)
         alert_h_d[`BIT_LINK_ERR] = 1'b1;
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         alert_l_q <= 8'h00;
         alert_h_q <= 8'h00;
         alert_n_q <= 1'b1;
      end
      else
      begin
         alert_l_q <= alert_l_d;
         alert_h_q <= alert_h_d;
         alert_n_q <= ~(|alert_l_d || |alert_h_d);
      end
   end

   // ****************************************
   // Transmitter
   // ****************************************
   // Oversized counts are clipped so the body never runs past the buffer
   assign tx_len = (tx_buf_q[0] > `MAX_PAYLOAD) ? `MAX_PAYLOAD : tx_buf_q[0];

   // Bit to send and phase length per state
   always_comb
   begin
      tx_bit = 1'b0;
      phase_last = 8'h00;
      tx_next = pd_msg_pkg::TX_IDLE;
      unique case (tx_st_q)
         pd_msg_pkg::TX_IDLE: tx_next = pd_msg_pkg::TX_IDLE;
         pd_msg_pkg::TX_PRE:
         begin
            tx_bit = bitcnt_q[0];
            phase_last = `PRE_LAST;
            tx_next = pd_msg_pkg::TX_SOP;
         end
         pd_msg_pkg::TX_SOP:
         begin
            tx_bit = SOP[bitcnt_q[2:0]];
            phase_last = `SOP_LAST;
            tx_next = pd_msg_pkg::TX_BODY;
         end
         pd_msg_pkg::TX_BODY:
         begin
            tx_bit = tx_buf_q[bitcnt_q[7:3]][bitcnt_q[2:0]];
            phase_last = {5'(tx_len), 3'h7};
            tx_next = pd_msg_pkg::TX_CRC;
         end
         pd_msg_pkg::TX_CRC:
         begin
            tx_bit = tx_crc_q[0];
            phase_last = `CRC_LAST;
            tx_next = pd_msg_pkg::TX_TAIL;
         end
         // Two quiet bit times so the far receiver ends the frame before release
         pd_msg_pkg::TX_TAIL:
         begin
            phase_last = `TAIL_LAST;
            tx_next = pd_msg_pkg::TX_IDLE;
         end
      endcase
   end

   assign tx_done = (tx_st_q == pd_msg_pkg::TX_TAIL) && (ui_q == `UI_LAST) && (bitcnt_q == `TAIL_LAST);

   // Edge at each bit start, extra mid-bit edge for a one
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i || (tx_st_q == pd_msg_pkg::TX_IDLE))
      begin
         ui_q <= 3'h0;
         bitcnt_q <= 8'h00;
         tx_crc_q <= `CRC_INIT;
         line_q <= 1'b0;
         tx_st_q <= (!rst_i && launch) ? pd_msg_pkg::TX_PRE : pd_msg_pkg::TX_IDLE;
      end
      else
      begin
         ui_q <= (ui_q == `UI_LAST) ? 3'h0 : 3'(ui_q + 3'h1);
         // Tail gets one closing edge, else the last bit is never decoded
         if (((tx_st_q != pd_msg_pkg::TX_TAIL) || (bitcnt_q == 8'h00))
             && ((ui_q == 3'h0) || ((ui_q == `UI_HALF) && tx_bit)))
            line_q <= ~line_q;
         if (ui_q == `UI_LAST)
         begin
            if (tx_st_q == pd_msg_pkg::TX_BODY)
               tx_crc_q <= crc_step(tx_crc_q, tx_bit);
            else if (tx_st_q == pd_msg_pkg::TX_CRC)
               tx_crc_q <= {1'b0, tx_crc_q[31:1]};
            if (bitcnt_q == phase_last)
            begin
               bitcnt_q <= 8'h00;
               tx_st_q <= tx_next;
            end
            else
               bitcnt_q <= 8'(bitcnt_q + 8'h01);
         end
      end
   end

   assign cc_o = line_q;
   assign cc_oe_n_o = (tx_st_q == pd_msg_pkg::TX_IDLE);
   assign tx_busy_o = (tx_st_q != pd_msg_pkg::TX_IDLE);

   // ****************************************
   // Receiver
   // ****************************************
   // Pin synchroniser, third stage only for edge finding
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
         {cc_s1_q, cc_s2_q, cc_s3_q} <= 3'h0;
      else
         {cc_s1_q, cc_s2_q, cc_s3_q} <= {cc_i, cc_s1_q, cc_s2_q};
   end

   assign rx_edge = cc_s2_q ^ cc_s3_q;
   assign rx_bit = (gap_q <= `SHORT_MAX);
   // Own echo is ignored while sending
   assign rx_bit_v = rx_edge && !tx_busy_o && (!rx_bit || half_q);
   assign rx_end = (gap_q == `IDLE_LAST) && !rx_edge;
   assign rx_byte = {rx_bit, rx_sh_q[7:1]};

   // Edge spacing: two short gaps a one, one long gap a zero
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         gap_q <= 4'h0;
         half_q <= 1'b0;
      end
      else if (rx_edge)
      begin
         gap_q <= 4'h0;
         half_q <= rx_bit && !half_q;
      end
      else if (gap_q != `IDLE_CYC)
         gap_q <= 4'(gap_q + 4'h1);
   end

   // Frame: hunt for start code, then length, payload, CRC
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i || rx_end)
      begin
         rx_st_q <= pd_msg_pkg::RX_HUNT;
         rx_sh_q <= 8'h00;
         rx_n_q <= 9'h000;
         rx_len_q <= 8'h00;
         rx_dl_q <= 32'h00000000;
         rx_crc_q <= `CRC_INIT;
      end
      else if (rx_bit_v)
      begin
         rx_sh_q <= rx_byte;
         if (rx_st_q == pd_msg_pkg::RX_HUNT)
            rx_st_q <= (rx_byte == SOP) ? pd_msg_pkg::RX_BODY : pd_msg_pkg::RX_HUNT;
         else
         begin
            if (rx_n_q != 9'h1FF)
               rx_n_q <= 9'(rx_n_q + 9'h001);
            rx_dl_q <= {rx_bit, rx_dl_q[31:1]};
            // Last 32 bits held back: they are the CRC itself
            if (rx_n_q >= 9'h020)
               rx_crc_q <= crc_step(rx_crc_q, rx_dl_q[0]);
            if (rx_n_q == 9'h007)
               rx_len_q <= rx_byte;
         end
      end
   end

   assign rx_ok = rx_end && (rx_st_q == pd_msg_pkg::RX_BODY) && (rx_len_q <= `MAX_PAYLOAD)
                  && (rx_n_q == {6'(rx_len_q + 8'h05), 3'h0}) && (rx_dl_q == rx_crc_q);
   assign rx_byte_v = rx_bit_v && (rx_st_q == pd_msg_pkg::RX_BODY) && (rx_n_q[2:0] == 3'h7);
   assign rx_wr_idx = 6'(rx_n_q[8:3] + 6'h01);

   // Payload lands as it arrives; nothing is erased between messages
   always_ff @(posedge ref_clk_i)
   begin
      if (rx_ok)
      begin
         rx_buf_q[0] <= 8'(rx_len_q + 8'h01);
         rx_buf_q[1] <= `SOP_TYPE;
      end
      // CRC bytes stay out, so older content past the count survives
      else if (rx_byte_v && (rx_n_q[8:3] != 6'h00) && (8'(rx_n_q[8:3]) <= rx_len_q)
               && (rx_wr_idx < 6'(`RXBUF_LEN)))
         rx_buf_q[rx_wr_idx[4:0]] <= rx_byte;
   end
endmodule

// >>> pd_port_manager.sv
// Port manager end: turns software register writes into link transfers
`timescale 1ns/1ns
`include "pd_msg_params.svh"
module pd_port_manager
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Software register port
   input wire logic [2:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // Alert seen on the link
   output logic alert_o,
   // Controller link
   pd_link_if.mgr link
);
   logic frame_q, ptr_ld_q, wr_stb_q, rd_stb_q, rd_wait_q, al_s1_q, al_s2_q;
   logic [7:0] ptr_val_q, wr_byte_q, rdat_q, rdata_q;

   // ****************************************
   // Link strobes
   // ****************************************
   // Frame stays open across a whole buffer load, else the send is refused
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         frame_q <= 1'b0;
         ptr_ld_q <= 1'b0;
         ptr_val_q <= 8'h00;
         wr_stb_q <= 1'b0;
         wr_byte_q <= 8'h00;
         rd_stb_q <= 1'b0;
      end
      else
      begin
         if (wr_i && (addr_i == `MGR_CTRL))
            frame_q <= wdata_i[0];
         ptr_ld_q <= wr_i && (addr_i == `MGR_PTR);
         if (wr_i && (addr_i == `MGR_PTR))
            ptr_val_q <= wdata_i;
         wr_stb_q <= wr_i && (addr_i == `MGR_WDATA);
         if (wr_i && (addr_i == `MGR_WDATA))
            wr_byte_q <= wdata_i;
         rd_stb_q <= wr_i && (addr_i == `MGR_RDREQ);
      end
   end

   assign link.frame = frame_q;
   assign link.ptr_ld = ptr_ld_q;
   assign link.ptr_val = ptr_val_q;
   assign link.wr_stb = wr_stb_q;
   assign link.wr_byte = wr_byte_q;
   assign link.rd_stb = rd_stb_q;

   // ****************************************
   // Read capture and alert
   // ****************************************
   // Byte comes back one cycle after the strobe
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         rd_wait_q <= 1'b0;
         rdat_q <= 8'h00;
      end
      else
      begin
         rd_wait_q <= rd_stb_q;
         if (rd_wait_q)
            rdat_q <= link.rd_byte;
      end
   end

   // Alert pin synchroniser; software then reads both alert registers
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
         {al_s1_q, al_s2_q} <= 2'h3;
      else
         {al_s1_q, al_s2_q} <= {link.alert_n, al_s1_q};
   end

   assign alert_o = ~al_s2_q;

   // Software read data, one cycle after the read strobe
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
         rdata_q <= 8'h00;
      else if (rd_i)
      begin
         unique case (addr_i)
            `MGR_CTRL: rdata_q <= {7'h00, frame_q};
            `MGR_PTR: rdata_q <= ptr_val_q;
            `MGR_RDATA: rdata_q <= rdat_q;
            `MGR_STATUS: rdata_q <= {5'h00, rd_stb_q || rd_wait_q, frame_q, ~al_s2_q};
            default: rdata_q <= 8'h00;
         endcase
      end
   end

   assign rdata_o = rdata_q;
endmodule

// >>> tb.sv
// Self-checking bench: two controller and manager pairs on one CC wire
`timescale 1ns/1ns
`include "pd_msg_params.svh"
module tb;
   logic ref_clk;
   logic rst;
   logic [2:0] addr [2];
   logic [7:0] wdata [2];
   logic wr [2];
   logic rd [2];
   logic [7:0] rdata [2];
   logic alert [2];
   logic cc_drv [2];
   logic cc_oe_n [2];
   logic busy [2];
   logic cc_wire;
   int error_cnt;
   int compares;

   pd_link_if link_a ();
   pd_link_if link_b ();

   // Wire pulled low when nobody drives
   assign cc_wire = !cc_oe_n[0] ? cc_drv[0] : (!cc_oe_n[1] ? cc_drv[1] : 1'b0);

   pd_port_ctrl i_pd_port_ctrl_a (.ref_clk_i(ref_clk), .rst_i(rst), .link(link_a), .cc_i(cc_wire),
      .cc_o(cc_drv[0]), .cc_oe_n_o(cc_oe_n[0]), .tx_busy_o(busy[0]));
   pd_port_ctrl i_pd_port_ctrl_b (.ref_clk_i(ref_clk), .rst_i(rst), .link(link_b), .cc_i(cc_wire),
      .cc_o(cc_drv[1]), .cc_oe_n_o(cc_oe_n[1]), .tx_busy_o(busy[1]));
   pd_port_manager i_pd_port_manager_a (.ref_clk_i(ref_clk), .rst_i(rst), .addr_i(addr[0]), .wdata_i(wdata[0]),
      .wr_i(wr[0]), .rd_i(rd[0]), .rdata_o(rdata[0]), .alert_o(alert[0]), .link(link_a));
   pd_port_manager i_pd_port_manager_b (.ref_clk_i(ref_clk), .rst_i(rst), .addr_i(addr[1]), .wdata_i(wdata[1]),
      .wr_i(wr[1]), .rd_i(rd[1]), .rdata_o(rdata[1]), .alert_o(alert[1]), .link(link_b));
   pd_link_assertions i_pd_link_assertions (.ref_clk_i(ref_clk), .rst_i(rst), .frame(link_a.frame),
      .ptr_ld(link_a.ptr_ld), .ptr_val(link_a.ptr_val), .wr_stb(link_a.wr_stb), .wr_byte(link_a.wr_byte),
      .rd_stb(link_a.rd_stb), .rd_byte(link_a.rd_byte), .alert_n(link_a.alert_n));

   initial ref_clk = 1'b0;
   always #50 ref_clk = ~ref_clk;

   // ****************************************
   // Access tasks
   // ****************************************
   task sw_wr(input int m, input logic [2:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      addr[m] <= a;
      wdata[m] <= d;
      wr[m] <= 1'b1;
      @(posedge ref_clk);
      wr[m] <= 1'b0;
   endtask

   task sw_rd(input int m, input logic [2:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      addr[m] <= a;
      rd[m] <= 1'b1;
      @(posedge ref_clk);
      rd[m] <= 1'b0;
      @(negedge ref_clk);
      d = rdata[m];
   endtask

   task check_byte(input string nm, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task check_bit(input string nm, input logic exp, input logic got);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %b seen %b", nm, exp, got);
      end
   endtask

   // One frame: pointer load then a burst of byte writes
   task dev_wr(input int m, input logic [7:0] a, input logic [7:0] q [$]);
      sw_wr(m, `MGR_CTRL, 8'h01);
      sw_wr(m, `MGR_PTR, a);
      foreach (q[i])
         sw_wr(m, `MGR_WDATA, q[i]);
      sw_wr(m, `MGR_CTRL, 8'h00);
   endtask

   // One frame: pointer load once, reads step through the map
   task dev_expect(input int m, input logic [7:0] a, input logic [7:0] q [$], input string nm);
      logic [7:0] d;
      sw_wr(m, `MGR_CTRL, 8'h01);
      sw_wr(m, `MGR_PTR, a);
      foreach (q[i])
      begin
         sw_wr(m, `MGR_RDREQ, 8'h00);
         repeat (3) @(posedge ref_clk);
         sw_rd(m, `MGR_RDATA, d);
         check_byte(nm, q[i], d);
      end
      sw_wr(m, `MGR_CTRL, 8'h00);
   endtask

   // Bounded wait for the alert level seen by a manager
   task wait_alert(input int m, input logic lvl, input int lim, input string nm);
      for (int i = 0; i < lim && alert[m] !== lvl; i++)
         @(negedge ref_clk);
      check_bit(nm, lvl, alert[m]);
   endtask

   // Load, launch, receive, read back and clear both flags
   task xfer(input int s, input int r, input logic [7:0] msg [$]);
      logic [7:0] exp [$];
      exp = {msg[0] + 8'h01, 8'h00, msg[1:$]};
      dev_wr(s, `ADDR_TXBUF, msg);
      dev_wr(s, `ADDR_CMD, {`CMD_SEND});
      check_bit("tx_busy", 1'b1, busy[s]);
      wait_alert(r, 1'b1, 3000, "rx_alert");
      wait_alert(s, 1'b1, 200, "tx_alert");
      dev_expect(r, `ADDR_ALERT_L, {8'h04, 8'h00}, "rx_flags");
      dev_expect(s, `ADDR_ALERT_L, {8'h40, 8'h00}, "tx_flags");
      dev_expect(r, `ADDR_RXBUF, exp, "rx_buffer");
      dev_wr(r, `ADDR_ALERT_L, {8'h04});
      dev_wr(s, `ADDR_ALERT_L, {8'h40});
      wait_alert(r, 1'b0, 20, "rx_alert_clear");
      wait_alert(s, 1'b0, 20, "tx_alert_clear");
   endtask

   task report_and_stop;
      if (error_cnt == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // ****************************************
   // Test sequence
   // ****************************************
   initial
   begin
      rst = 1'b1;
      for (int i = 0; i < 2; i++)
      begin
         addr[i] = 3'h0;
         wdata[i] = 8'h00;
         wr[i] = 1'b0;
         rd[i] = 1'b0;
      end
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      // Idle state and read-back of non-readable places
      dev_expect(0, `ADDR_ALERT_L, {8'h00, 8'h00}, "flags_idle");
      dev_expect(0, 8'h20, {8'h00}, "unmapped");
      dev_expect(0, `ADDR_TXBUF, {8'h00}, "tx_buffer_read");
      check_bit("alert_idle", 1'b0, alert[0]);
      // One data object, far end to near end
      xfer(1, 0, {8'h06, 8'h61, 8'h43, 8'hF0, 8'h90, 8'h01, 8'h00});
      // Split load must be refused at launch
      dev_wr(0, `ADDR_TXBUF, {8'h04, 8'h61});
      dev_wr(0, 8'h53, {8'h43, 8'h01, 8'h02});
      dev_wr(0, `ADDR_CMD, {`CMD_SEND});
      wait_alert(0, 1'b1, 20, "link_err_alert");
      dev_expect(0, `ADDR_ALERT_L, {8'h00, 8'h02}, "link_err_flags");
      dev_wr(0, `ADDR_ALERT_H, {8'h00});
      dev_expect(0, `ADDR_ALERT_H, {8'h02}, "zero_write_keeps");
      dev_wr(0, `ADDR_ALERT_H, {8'h02});
      wait_alert(0, 1'b0, 20, "link_err_clear");
      check_bit("no_send", 1'b0, alert[1]);
      // Unknown command byte launches nothing
      dev_wr(0, `ADDR_TXBUF, {8'h02, 8'h47, 8'h0C});
      dev_wr(0, `ADDR_CMD, {8'h31});
      repeat (1200) @(posedge ref_clk);
      check_bit("bad_cmd_far", 1'b0, alert[1]);
      check_bit("bad_cmd_busy", 1'b0, busy[0]);
      check_bit("bad_cmd_near", 1'b0, alert[0]);
      // Near end to far end, then a short message over older content
      xfer(0, 1, {8'h02, 8'h47, 8'h0C});
      xfer(1, 0, {8'h02, 8'h47, 8'h0C});
      dev_expect(0, 8'h34, {8'hF0, 8'h90, 8'h01, 8'h00}, "stale_bytes");
      report_and_stop();
   end

   // Watchdog well past the expected run length
   initial
   begin
      repeat (40000) @(posedge ref_clk);
      error_cnt++;
      report_and_stop();
   end
endmodule
